// [core/ddc_pkg.sv]
// constants for the delay calibration and page policy block
package ddc_pkg;
  // register byte offsets
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_RDSTAT = 8'h04;
  localparam logic [7:0] ADDR_WRSTAT = 8'h08;
  localparam logic [7:0] ADDR_OPER   = 8'h0c;
  localparam logic [7:0] ADDR_CMD    = 8'h10;
  // control register fields
  localparam int CTL_EN     = 0;
  localparam int CTL_LOAD   = 1;
  localparam int CTL_RDPH   = 2;
  localparam int CTL_WRPH   = 3;
  localparam int CTL_DLY_LO = 8;
  localparam int CTL_RO_LO  = 16;
  localparam int CTL_WO_LO  = 24;
  // status fields
  localparam int ST_OVF = 8;
  localparam int ST_UDF = 9;
  // operation register fields
  localparam int OP_DDR    = 0;
  localparam int OP_POL_LO = 1;
  localparam int OP_TMO_LO = 8;
  // command register fields
  localparam int CMD_DPD_IN  = 0;
  localparam int CMD_DPD_OUT = 1;
  // reset values
  localparam logic [31:0] CTRL_RST = 32'h0000_8000;
  localparam logic [31:0] OPER_RST = 32'h0000_0400;
  // counter limits and time-out scaling
  localparam logic [7:0] CNT_MAX  = 8'hff;
  localparam logic [7:0] CNT_MIN  = 8'h00;
  localparam logic [7:0] CNT_RST  = 8'h80;
  localparam logic [8:0] TMO_MUL  = 9'h004;
  localparam logic [8:0] TMO_ADD  = 9'h003;
  localparam int         NBANK    = 4;
  // row closing policies
  typedef enum logic [1:0] {
    DDC_KEEP_OPEN, DDC_CLOSE_AFTER, DDC_TIMED_CLOSE
  } ddc_policy_e;
endpackage

// [core/ddc_top.sv]
// delay calibration loops and row closing policy with apb registers
// How it works
// - phase select bit picks 72 or 90 degree nominal delay
// - counter takes a software preload value, as start or fixed
// - holding load with enable keeps the programmed delay fixed
// - preload acts only while enabled, enable held one cycle
// - clearing enable freezes counter, setting it resumes tracking
// - read and write offsets are 6-bit signed, +31 to -32
// - each loop has status with counter, overflow, underflow
// - overflow sets at count 255, underflow at count zero
// - writing enable to zero clears both flags
// - operation register selects memory type and one of three policies
// - keep-open tracks open row per bank, miss precharges, activates
// - close-after-access precharges after every read or write
// - timed close has one reloading row counter per bank
// - row time-out is programmed value times four plus three
// - command register issues deep power-down entry and exit
// - loop drives a continuously updated 8-bit code to delay lines
// - read loop feeds two strobe lines, write loop one data line
`timescale 1ns/1ns
module ddc_top (
  input  wire logic        i_clk_sys,
  input  wire logic        i_rst_n,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        i_rd_pd_up,
  input  wire logic        i_rd_pd_dn,
  input  wire logic        i_wr_pd_up,
  input  wire logic        i_wr_pd_dn,
  output logic [7:0]       o_rd_dl_hi_code,
  output logic [7:0]       o_rd_dl_lo_code,
  output logic [7:0]       o_wr_dl_code,
  output logic             o_rd_phase_90,
  output logic             o_wr_phase_90,
  output logic             o_ddr_mode,
  input  wire logic        i_acc_valid,
  input  wire logic [1:0]  i_acc_bank,
  input  wire logic [12:0] i_acc_row,
  input  wire logic        i_sdram_tick,
  output logic             o_row_hit,
  output logic             o_need_pre,
  output logic             o_need_act,
  output logic             o_pre_after,
  output logic [3:0]       o_close_req,
  output logic             o_dpd_enter,
  output logic             o_dpd_exit
);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  // saturating sum of code and signed offset
  function automatic logic [7:0] add_ofs(input logic [7:0] c,
                                         input logic [5:0] o);
    logic [9:0] s;
    s = {2'b00, c} + {{4{o[5]}}, o};
    if (s[9])
      add_ofs = ddc_pkg::CNT_MIN;
    else if (s[8])
      add_ofs = ddc_pkg::CNT_MAX;
    else
      add_ofs = s[7:0];
  endfunction
  // one tracking step, stops at the ends instead of wrapping
  function automatic logic [7:0] step(input logic [7:0] c,
                                      input logic up, input logic dn);
    step = c;
    if (up && !dn && c != ddc_pkg::CNT_MAX)
      step = c + 8'h01;
    else if (dn && !up && c != ddc_pkg::CNT_MIN)
      step = c - 8'h01;
  endfunction

  // ------------------------------------------------------------
  // apb decode and registers
  // ------------------------------------------------------------
  logic [31:0] ctrl_r;
  logic [31:0] oper_r;
  logic [7:0]  rd_cnt_r;
  logic [7:0]  wr_cnt_r;
  logic [1:0]  rd_flg_r;
  logic [1:0]  wr_flg_r;
  logic        dpd_r;
  logic        wr_en;
  logic        hit_map;
  logic        en_off_wr;
  logic        calib_enable;
  logic        load_force;
  logic [7:0]  delay_val;
  logic [6:0]  tmo_prog;
  logic [8:0]  tmo_load;
  ddc_pkg::ddc_policy_e policy;

  assign hit_map = paddr inside {ddc_pkg::ADDR_CTRL, ddc_pkg::ADDR_RDSTAT,
      ddc_pkg::ADDR_WRSTAT, ddc_pkg::ADDR_OPER, ddc_pkg::ADDR_CMD};
  assign pready  = 1'b1;
  assign pslverr = psel && penable && !hit_map;
  assign wr_en   = psel && penable && pwrite && hit_map;
  // writing the enable low wipes the sticky loop flags
  assign en_off_wr = wr_en && paddr == ddc_pkg::ADDR_CTRL &&
                     !pwdata[ddc_pkg::CTL_EN];
  assign calib_enable = ctrl_r[ddc_pkg::CTL_EN];
  assign load_force   = ctrl_r[ddc_pkg::CTL_LOAD];
  assign delay_val    = ctrl_r[ddc_pkg::CTL_DLY_LO +: 8];
  assign policy   = ddc_pkg::ddc_policy_e'(oper_r[ddc_pkg::OP_POL_LO +: 2]);
  assign tmo_prog = oper_r[ddc_pkg::OP_TMO_LO +: 7];
  // effective time-out in sdram clocks
  assign tmo_load = {2'b00, tmo_prog} * ddc_pkg::TMO_MUL
                    + ddc_pkg::TMO_ADD;

  // software writable registers
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      ctrl_r <= ddc_pkg::CTRL_RST;
      oper_r <= ddc_pkg::OPER_RST;
    end else if (wr_en) begin
      if (paddr == ddc_pkg::ADDR_CTRL)
        ctrl_r <= pwdata;
      if (paddr == ddc_pkg::ADDR_OPER)
        oper_r <= {17'h0, pwdata[14:8], 5'h0, pwdata[2:0]};
    end
  end

  // read data is captured in the setup cycle, so it is a flop output
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n)
      prdata <= 32'h0;
    else if (psel && !penable) begin
      case (paddr)
        ddc_pkg::ADDR_CTRL:   prdata <= ctrl_r;
        ddc_pkg::ADDR_RDSTAT: prdata <= {22'h0, rd_flg_r, rd_cnt_r};
        ddc_pkg::ADDR_WRSTAT: prdata <= {22'h0, wr_flg_r, wr_cnt_r};
        ddc_pkg::ADDR_OPER:   prdata <= oper_r;
        ddc_pkg::ADDR_CMD:    prdata <= {31'h0, dpd_r};
        default:              prdata <= 32'h0;
      endcase
    end
  end

  // ------------------------------------------------------------
  // deep power-down commands
  // ------------------------------------------------------------
  // one-cycle command pulses; dpd_r shows the last command given
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_dpd_enter <= 1'b0;
      o_dpd_exit  <= 1'b0;
      dpd_r       <= 1'b0;
    end else begin
      o_dpd_enter <= wr_en && paddr == ddc_pkg::ADDR_CMD &&
                     pwdata[ddc_pkg::CMD_DPD_IN];
      o_dpd_exit  <= wr_en && paddr == ddc_pkg::ADDR_CMD &&
                     pwdata[ddc_pkg::CMD_DPD_OUT];
      dpd_r       <= o_dpd_enter || (dpd_r && !o_dpd_exit);
    end
  end

  // ------------------------------------------------------------
  // calibration loops
  // ------------------------------------------------------------
  // detector outputs come from the analog delay loop: two flops each
  logic [3:0] pd_s1_r;
  logic [3:0] pd_s2_r;
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      pd_s1_r <= 4'h0;
      pd_s2_r <= 4'h0;
    end else begin
      pd_s1_r <= {i_wr_pd_dn, i_wr_pd_up, i_rd_pd_dn, i_rd_pd_up};
      pd_s2_r <= pd_s1_r;
    end
  end

  // load beats tracking; a disabled loop holds its count
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_cnt_r <= ddc_pkg::CNT_RST;
      wr_cnt_r <= ddc_pkg::CNT_RST;
    end else if (calib_enable) begin
      if (load_force) begin
        rd_cnt_r <= delay_val;
        wr_cnt_r <= delay_val;
      end else begin
        rd_cnt_r <= step(rd_cnt_r, pd_s2_r[0], pd_s2_r[1]);
        wr_cnt_r <= step(wr_cnt_r, pd_s2_r[2], pd_s2_r[3]);
      end
    end
  end

  // sticky flags {underflow, overflow}; a hit beats the clear
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      rd_flg_r <= 2'b00;
      wr_flg_r <= 2'b00;
    end else begin
      rd_flg_r <= (en_off_wr ? 2'b00 : rd_flg_r) |
                  {rd_cnt_r == ddc_pkg::CNT_MIN,
                   rd_cnt_r == ddc_pkg::CNT_MAX};
      wr_flg_r <= (en_off_wr ? 2'b00 : wr_flg_r) |
                  {wr_cnt_r == ddc_pkg::CNT_MIN,
                   wr_cnt_r == ddc_pkg::CNT_MAX};
    end
  end

  // delay line codes: offset applied, registered so lines see no glitch
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_rd_dl_hi_code <= ddc_pkg::CNT_RST;
      o_rd_dl_lo_code <= ddc_pkg::CNT_RST;
      o_wr_dl_code    <= ddc_pkg::CNT_RST;
      o_rd_phase_90   <= 1'b0;
      o_wr_phase_90   <= 1'b0;
      o_ddr_mode      <= 1'b0;
    end else begin
      o_rd_dl_hi_code <= add_ofs(rd_cnt_r,
                           ctrl_r[ddc_pkg::CTL_RO_LO +: 6]);
      o_rd_dl_lo_code <= add_ofs(rd_cnt_r,
                           ctrl_r[ddc_pkg::CTL_RO_LO +: 6]);
      o_wr_dl_code    <= add_ofs(wr_cnt_r,
                           ctrl_r[ddc_pkg::CTL_WO_LO +: 6]);
      o_rd_phase_90   <= ctrl_r[ddc_pkg::CTL_RDPH];
      o_wr_phase_90   <= ctrl_r[ddc_pkg::CTL_WRPH];
      o_ddr_mode      <= oper_r[ddc_pkg::OP_DDR];
    end
  end

  // ------------------------------------------------------------
  // row closing policy
  // ------------------------------------------------------------
  logic [3:0]  open_r;
  logic [12:0] row_r [ddc_pkg::NBANK];
  logic [8:0]  tmo_r [ddc_pkg::NBANK];
  logic        acc_open;
  logic        acc_match;
  assign acc_open  = open_r[i_acc_bank];
  assign acc_match = acc_open && row_r[i_acc_bank] == i_acc_row;

  // access answers: hit, or precharge then activate
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      o_row_hit   <= 1'b0;
      o_need_pre  <= 1'b0;
      o_need_act  <= 1'b0;
      o_pre_after <= 1'b0;
    end else begin
      o_row_hit   <= i_acc_valid && acc_match;
      o_need_pre  <= i_acc_valid && acc_open && !acc_match;
      o_need_act  <= i_acc_valid && !acc_match;
      o_pre_after <= i_acc_valid &&
                     policy == ddc_pkg::DDC_CLOSE_AFTER;
    end
  end

  // per bank open row and time-out; a new access wins over a close
  always_ff @(posedge i_clk_sys or negedge i_rst_n) begin
    if (!i_rst_n) begin
      open_r      <= 4'h0;
      o_close_req <= 4'h0;
      for (int b = 0; b < ddc_pkg::NBANK; b++) begin
        row_r[b] <= 13'h0;
        tmo_r[b] <= 9'h0;
      end
    end else begin
      for (int b = 0; b < ddc_pkg::NBANK; b++) begin
        o_close_req[b] <= 1'b0;
        if (i_acc_valid && i_acc_bank == 2'(b)) begin
          row_r[b]  <= i_acc_row;
          open_r[b] <= policy != ddc_pkg::DDC_CLOSE_AFTER;
          tmo_r[b]  <= tmo_load;
        end else if (policy == ddc_pkg::DDC_TIMED_CLOSE && open_r[b] &&
                     i_sdram_tick) begin
          if (tmo_r[b] == 9'h0) begin
            open_r[b]      <= 1'b0;
            o_close_req[b] <= 1'b1;
          end else
            tmo_r[b] <= tmo_r[b] - 9'h1;
        end else if (policy == ddc_pkg::DDC_CLOSE_AFTER)
          open_r[b] <= 1'b0;
      end
    end
  end

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  AST_PRELOAD: assert property (
    calib_enable && load_force |=> rd_cnt_r == $past(delay_val) &&
                                   wr_cnt_r == $past(delay_val))
    else $error("preload not taken");
  AST_FREEZE: assert property (
    !calib_enable |=> $stable(rd_cnt_r) && $stable(wr_cnt_r))
    else $error("disabled counter moved");
  AST_OVF: assert property (
    rd_cnt_r == 8'hff |=> rd_flg_r[0] ##1 (rd_flg_r[0] || $past(en_off_wr)))
    else $error("overflow not set");
  AST_UDF: assert property (
    wr_cnt_r == 8'h00 |=> wr_flg_r[1] ##1 (wr_flg_r[1] || $past(en_off_wr)))
    else $error("underflow not set");
  AST_FLAG_CLR: assert property (
    en_off_wr && rd_cnt_r != 8'hff && rd_cnt_r != 8'h00 |=>
      rd_flg_r == 2'b00)
    else $error("flags not cleared");
  AST_SAT: assert property (
    calib_enable && !load_force && rd_cnt_r == 8'hff |=> rd_cnt_r != 8'h00)
    else $error("counter wrapped");
  AST_TRACK: assert property (
    calib_enable && !load_force && pd_s2_r[0] && !pd_s2_r[1] &&
    rd_cnt_r != 8'hff |=> rd_cnt_r == $past(rd_cnt_r) + 8'h01)
    else $error("tracking step wrong");
  AST_CLOSE_AFTER: assert property (
    i_acc_valid && policy == ddc_pkg::DDC_CLOSE_AFTER |=>
      o_pre_after ##1 !open_r[$past(i_acc_bank, 2)])
    else $error("row left open");
  AST_HIT: assert property (
    i_acc_valid && acc_match |=> o_row_hit && !o_need_act)
    else $error("hit not flagged");
  AST_TMO_LOAD: assert property (
    i_acc_valid |=> tmo_r[$past(i_acc_bank)] ==
      {2'b00, $past(tmo_prog)} * 9'd4 + 9'd3)
    else $error("time-out load wrong");
  AST_DPD: assert property (
    o_dpd_enter && !o_dpd_exit |=> dpd_r)
    else $error("deep power-down state wrong");
endmodule // ddc_top

// [tb/ddc_pd_model.sv]
// phase detector stand-in for one calibration loop
`timescale 1ns/1ns
module ddc_pd_model (
  input  wire logic [7:0] i_code,
  input  wire logic [7:0] i_target,
  output logic            o_up,
  output logic            o_dn
);
  // ------------------------------------------------------------
  // detector
  // ------------------------------------------------------------
  // compares the delay line code with the lock point; the real loop
  // dithers at lock because of its input synchroniser
  always_comb begin
    o_up = (i_code < i_target);
    o_dn = (i_code > i_target);
  end
endmodule // ddc_pd_model

// [tb/ddc_top_test.sv]
// self-checking bench for the calibration and row policy block
`timescale 1ns/1ns
module ddc_top_test;
  logic        clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0;
  logic        av = 0, tick = 0, pready, pslverr, er;
  logic [7:0]  paddr = 0, tg_rd = 8'hff, tg_wr = 8'h00;
  logic [7:0]  hi_c, lo_c, wr_c;
  logic [31:0] pwdata = 0, prdata, rd;
  logic        ru, rdn, wu, wdn, rph, wph, ddr, hit, npre, nact;
  logic        pafter, dpd_in, dpd_out;
  logic [1:0]  bk = 0, b;
  logic [12:0] row = 0, r;
  logic [3:0]  cls;
  int          n_errors = 0, check_count = 0, cyc = 0, n, dv, tm;
  int          opn [4] = '{default:0};
  int          orow [4];

  ddc_top u_ddc_top (
    .i_clk_sys(clk), .i_rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .i_rd_pd_up(ru),
    .i_rd_pd_dn(rdn), .i_wr_pd_up(wu), .i_wr_pd_dn(wdn),
    .o_rd_dl_hi_code(hi_c), .o_rd_dl_lo_code(lo_c), .o_wr_dl_code(wr_c),
    .o_rd_phase_90(rph), .o_wr_phase_90(wph), .o_ddr_mode(ddr),
    .i_acc_valid(av), .i_acc_bank(bk), .i_acc_row(row),
    .i_sdram_tick(tick), .o_row_hit(hit), .o_need_pre(npre),
    .o_need_act(nact), .o_pre_after(pafter), .o_close_req(cls),
    .o_dpd_enter(dpd_in), .o_dpd_exit(dpd_out));
  ddc_pd_model u_ddc_pd_model (
    .i_code(lo_c), .i_target(tg_rd), .o_up(ru), .o_dn(rdn));
  ddc_pd_model u_ddc_pd_model_wr (
    .i_code(wr_c), .i_target(tg_wr), .o_up(wu), .o_dn(wdn));

  // ------------------------------------------------------------
  // clock, watchdog and helpers
  // ------------------------------------------------------------
  initial begin
    forever #20 clk = ~clk;
  end

  // a hang is cut short well beyond the longest expected run
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_errors++;
      conclude();
    end
  end

  task automatic chk(input string nm, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // control word: read loop at 90 degrees, write loop at 72
  function automatic logic [31:0] cw(int en, ld, d, ro, wo);
    cw = {2'b0, wo[5:0], 2'b0, ro[5:0], d[7:0], 4'h0, 1'b0, 1'b1, ld[0],
          en[0]};
  endfunction

  // one access; expected flags come from the open-row model
  task automatic acc(input logic [1:0] ab, input logic [12:0] ar,
                     input int pol);
    logic [3:0] ex;
    ex = (pol == 1) ? 4'h3 : (opn[ab] == 0) ? 4'h2 :
         (orow[ab] == ar) ? 4'h8 : 4'h6;
    opn[ab] = (pol != 1);
    orow[ab] = ar;
    @(posedge clk);
    av <= 1'b1;
    bk <= ab;
    row <= ar;
    @(posedge clk);
    av <= 1'b0;
    @(posedge clk);
    chk("acc", {hit, npre, nact, pafter}, ex);
  endtask

  task automatic conclude();
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    dv = $urandom(32'h0083);
    dv = 32 + $urandom % 192;
    tm = 4 + $urandom % 4;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
    apb(1'b0, 8'h00, 0);
    chk("ctrl_rst", rd, 32'h0000_8000);
    apb(1'b0, 8'h0c, 0);
    chk("oper_rst", rd, 32'h0000_0400);
    apb(1'b1, 8'h04, 32'hffff_ffff);
    apb(1'b0, 8'h04, 0);
    chk("rdstat_rst", rd, 32'h80);
    chk("codes_rst", {hi_c, lo_c, wr_c}, 24'h808080);
    apb(1'b0, 8'h14, 0);
    chk("unmapped", {er, rd[30:0]}, 32'h8000_0000);
    $display("test reset done");
    // load held while the detector pushes: code must not move
    apb(1'b1, 8'h00, cw(1, 1, dv[7:0], 0, 0));
    repeat (20) @(posedge clk);
    apb(1'b0, 8'h00, 0);
    chk("ctrl", rd, cw(1, 1, dv[7:0], 0, 0));
    apb(1'b0, 8'h04, 0);
    chk("rd_load", rd, dv);
    apb(1'b0, 8'h08, 0);
    chk("wr_load", rd, dv);
    chk("codes", {hi_c, lo_c, wr_c}, {3{dv[7:0]}});
    chk("phase", {rph, wph}, 2'b10);
    apb(1'b1, 8'h00, cw(1, 1, dv[7:0], 6'h08, 6'h2e));
    repeat (4) @(posedge clk);
    chk("offs", {hi_c, lo_c, wr_c},
        {8'(dv+8), 8'(dv+8), 8'(dv-18)});
    $display("test load done");
    // mid-scale entry at 128, then both loops run into their end stops
    apb(1'b1, 8'h00, cw(1, 1, 8'd128, 0, 0));
    apb(1'b1, 8'h00, cw(1, 0, 8'd128, 0, 0));
    repeat (336) @(posedge clk);
    apb(1'b0, 8'h04, 0);
    chk("rd_ovf", rd, 32'h1ff);
    apb(1'b0, 8'h08, 0);
    chk("wr_udf", rd, 32'h200);
    // bench clock is below lock range: forced delay 104, write offset -18
    apb(1'b1, 8'h00, cw(1, 1, 8'd104, 0, 6'h2e));
    apb(1'b1, 8'h00, cw(0, 0, 8'd104, 0, 6'h2e));
    repeat (20) @(posedge clk);
    chk("unlk_codes", {hi_c, lo_c, wr_c}, 24'h686856);
    apb(1'b0, 8'h04, 0);
    chk("rd_frz", rd, 32'd104);
    apb(1'b0, 8'h08, 0);
    chk("wr_frz", rd, 32'd104);
    tg_rd <= 8'h70;
    tg_wr <= 8'h58;
    apb(1'b1, 8'h00, cw(1, 0, 8'd104, 0, 0));
    repeat (60) @(posedge clk);
    apb(1'b0, 8'h04, 0);
    chk("rd_resume", (rd - 32'h6c) <= 32'h8, 1);
    apb(1'b0, 8'h08, 0);
    chk("wr_resume", (rd - 32'h54) <= 32'h8, 1);
    $display("test tracking done");
    // each row policy in turn, with first access, repeat and miss
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, 8'h0c, {17'h0, tm[6:0], 5'h0, p[1:0], p[0]});
      chk("oper_err", er, 1'b0);
      apb(1'b0, 8'h0c, 0);
      chk("oper", rd, {17'h0, tm[6:0], 5'h0, p[1:0], p[0]});
      chk("ddr", ddr, p[0]);
      if (p == 1) opn = '{default:0};
      b = 2'($urandom % 4);
      r = 13'($urandom % 8000);
      acc(b, r, p);
      acc(b, r, p);
      acc(b, r + 13'h1, p);
    end
    tick <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (cls[b] !== 1'b1 && n < 200);
    tick <= 1'b0;
    chk("close_ticks", n, tm * 4 + 5);
    opn[b] = 0;
    acc(b, r + 13'h1, 2);
    $display("test policy done");
    // deep power-down entry then exit, one pulse each
    for (int c = 0; c < 2; c++) begin
      apb(1'b1, 8'h10, c + 1);
      n = 0;
      repeat (3) begin
        @(posedge clk);
        n += (c == 0) ? dpd_in : dpd_out;
      end
      chk("dpd_pulse", n, 1);
      apb(1'b0, 8'h10, 0);
      chk("dpd_state", rd[0], c == 0);
    end
    $display("test power-down done");
    conclude();
  end
endmodule // ddc_top_test
